/* design/lhcd_decoder.sv */
/*
  host command decoder with display memory, address pointers and status byte.
  assumes host pins are asynchronous to clk and stable around the strobe edges;
  the bus mode front end has already turned the bus into write and read levels.
*/
`timescale 1ns/1ps

// Summary of operation
// R1 - host drives select low for commands
// R2 - data access uses page and column pointers
// R3 - pointers step after every data access
// R4 - no wrap: column stops at last column
// R5 - wrap: column clears, page steps once
// R6 - page wraps between both memory ends
// R7 - direction bit: clear plus, set minus
// R8 - cursor mode: write-only advance, no wrap
// R9 - software writes zero to reserved bits
// R10 - status byte: busy, mirror, enable, reset
// R11 - accesses accepted while busy, reset clear
// R12 - host locked out during reset in progress, except for status reads
// R13 - status mirrors column mirror and enable
// R14 - column pointer loaded by two nibbles
// R15 - unknown command patterns have no guaranteed effect
// R16 - pump bit 0 selects panel loading
// R17 - pump bits 2:1 select voltage source
// R18 - start line scrolls image 0 to 63
// R19 - operating state reset, sleep, normal
// R20 - display control invert, all on, on
// R21 - mapping msb first, column, row mirror
// R22 - multiplex rate taken from rate pins
// R23 - double-byte command takes next command byte
// R24 - each command changes only its field
module lhcd_decoder #(
  parameter int RESET_CYCLES = lhcd_pkg::RESET_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              rst_pin_n,
  input  wire logic              chip_select0_n,
  input  wire logic              chip_select1,
  input  wire logic              command_data_select,
  input  wire logic              host_write,
  input  wire logic              host_read,
  input  wire logic [7:0]        host_data_in,
  input  wire logic [1:0]        rate_pins,
  input  wire logic [1:0]        bias_pins,
  output lhcd_pkg::lhcd_cfg_t    cfg,
  output logic      [1:0]        multiplex_rate,
  output logic      [1:0]        operating_state,
  output logic                   internal_busy_flag,
  output logic                   reset_in_progress,
  output logic      [7:0]        host_data_out,
  output logic                   host_data_oe
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  localparam int CW = $clog2(RESET_CYCLES + 1);
  localparam int SW = 18;

  function automatic lhcd_pkg::lhcd_cmd_t decode_cmd(input logic [7:0] b);
    lhcd_pkg::lhcd_cmd_t c;
    c = lhcd_pkg::CMD_UNDEF;
    if ((b & lhcd_pkg::M_NIB) == lhcd_pkg::V_CAL) c = lhcd_pkg::CMD_CAL;
    else if ((b & lhcd_pkg::M_NIB) == lhcd_pkg::V_CAH) c = lhcd_pkg::CMD_CAH;
    else if ((b & lhcd_pkg::M_3) == lhcd_pkg::V_GN) c = lhcd_pkg::CMD_GN;
    else if ((b & lhcd_pkg::M_3) == lhcd_pkg::V_PC) c = lhcd_pkg::CMD_PC;
    else if ((b & lhcd_pkg::M_1) == lhcd_pkg::V_APC) c = lhcd_pkg::CMD_APC;
    else if ((b & lhcd_pkg::M_SL) == lhcd_pkg::V_SL) c = lhcd_pkg::CMD_SL;
    else if ((b & lhcd_pkg::M_NIB) == lhcd_pkg::V_PA) c = lhcd_pkg::CMD_PA;
    else if (b == lhcd_pkg::V_PM) c = lhcd_pkg::CMD_PM;
    else if ((b & lhcd_pkg::M_AC) == lhcd_pkg::V_AC) c = lhcd_pkg::CMD_AC;
    else if ((b & lhcd_pkg::M_1) == lhcd_pkg::V_MY) c = lhcd_pkg::CMD_MY;
    else if ((b & lhcd_pkg::M_1) == lhcd_pkg::V_APO) c = lhcd_pkg::CMD_APO;
    else if ((b & lhcd_pkg::M_1) == lhcd_pkg::V_INV) c = lhcd_pkg::CMD_INV;
    else if ((b & lhcd_pkg::M_1) == lhcd_pkg::V_ON) c = lhcd_pkg::CMD_ON;
    else if ((b & lhcd_pkg::M_LC) == lhcd_pkg::V_LC) c = lhcd_pkg::CMD_LC;
    else if (b == lhcd_pkg::V_SRST) c = lhcd_pkg::CMD_SRST;
    else if (b == lhcd_pkg::V_NOP) c = lhcd_pkg::CMD_NOP;
    else if ((b & lhcd_pkg::M_2) == lhcd_pkg::V_BR) c = lhcd_pkg::CMD_BR;
    else if (b == lhcd_pkg::V_CRST) c = lhcd_pkg::CMD_CRST;
    else if (b == lhcd_pkg::V_CSET) c = lhcd_pkg::CMD_CSET;
    else if ((b & lhcd_pkg::M_2) == lhcd_pkg::V_TST) c = lhcd_pkg::CMD_TST;
    return c;
  endfunction

  function automatic logic [7:0] swap_bits(input logic [7:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7 - i];
    end
    return r;
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [SW-1:0] pins_raw;
  logic [SW-1:0] pins_s1;
  logic [SW-1:0] pins_s2;
  logic          wr_s3;
  logic          rd_s3;

  assign pins_raw = {rst_pin_n, chip_select0_n, chip_select1, command_data_select,
                     host_write, host_read, host_data_in, rate_pins, bias_pins};

  genvar g;
  generate
    for (g = 0; g < SW; g++) begin : g_sync
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          pins_s1[g] <= 1'b0;
          pins_s2[g] <= 1'b0;
        end else begin
          pins_s1[g] <= pins_raw[g];
          pins_s2[g] <= pins_s1[g];
        end
      end
    end
  endgenerate

  logic       rst_pin_s;
  logic       cs_s;
  logic       cd_s;
  logic       wr_s;
  logic       rd_s;
  logic [7:0] din_s;
  logic [1:0] rate_s;
  logic [1:0] bias_s;

  assign rst_pin_s = pins_s2[17];
  assign cs_s      = ~pins_s2[16] & pins_s2[15];
  assign cd_s      = pins_s2[14];
  assign wr_s      = pins_s2[13];
  assign rd_s      = pins_s2[12];
  assign din_s     = pins_s2[11:4];
  assign rate_s    = pins_s2[3:2];
  assign bias_s    = pins_s2[1:0];

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_s3 <= 1'b0;
      rd_s3 <= 1'b0;
    end else begin
      wr_s3 <= wr_s;
      rd_s3 <= rd_s;
    end
  end

  // ****************************************************************
  // access qualification
  // ****************************************************************
  logic                wr_edge;
  logic                rd_edge;
  logic                take_cmd;
  logic                take_wdata;
  logic                take_rdata;
  logic                take_status;
  lhcd_pkg::lhcd_cmd_t cmd;
  logic                sys_reset_cmd;
  logic                int_reset;

  assign wr_edge = wr_s & ~wr_s3 & cs_s;
  assign rd_edge = rd_s & ~rd_s3 & cs_s;
  // R1 select level splits command and data
  // R11 R12 command and data accesses gated only by reset
  assign take_cmd    = wr_edge & ~cd_s & ~reset_in_progress;
  assign take_wdata  = wr_edge & cd_s & ~reset_in_progress;
  assign take_rdata  = rd_edge & cd_s & ~reset_in_progress;
  assign take_status = rd_edge & ~cd_s;
  assign cmd         = decode_cmd(din_s);

  // ****************************************************************
  // double-byte command tracking
  // ****************************************************************
  typedef enum logic [1:0] {PEND_NONE, PEND_PM, PEND_APC, PEND_TST} lhcd_pend_t;
  lhcd_pend_t pend;
  logic       second_byte;

  assign second_byte   = take_cmd & (pend != PEND_NONE);
  assign sys_reset_cmd = take_cmd & ~second_byte & (cmd == lhcd_pkg::CMD_SRST);

  // R23 second byte is a parameter
  always_ff @(posedge clk) begin
    if (int_reset) begin
      pend <= PEND_NONE;
    end else if (second_byte) begin
      pend <= PEND_NONE;
    end else if (take_cmd) begin
      case (cmd)
        lhcd_pkg::CMD_PM:  pend <= PEND_PM;
        lhcd_pkg::CMD_APC: pend <= PEND_APC;
        lhcd_pkg::CMD_TST: pend <= PEND_TST;
        default:           pend <= PEND_NONE;
      endcase
    end
  end

  // ****************************************************************
  // reset sequencing
  // ****************************************************************
  logic [CW-1:0] reset_count;

  assign int_reset = ~reset_n | ~rst_pin_s | sys_reset_cmd;

  // R12 host held off while reset runs
  always_ff @(posedge clk) begin
    if (int_reset) begin
      reset_count       <= CW'(RESET_CYCLES);
      reset_in_progress <= 1'b1;
    end else if (reset_count != '0) begin
      reset_count       <= reset_count - 1'b1;
      reset_in_progress <= (reset_count != CW'(1));
    end else begin
      reset_in_progress <= 1'b0;
    end
  end

  // R19 operating state follows reset and enable
  always_ff @(posedge clk) begin
    if (int_reset) begin
      operating_state    <= lhcd_pkg::OS_RESET;
      internal_busy_flag <= 1'b1;
    end else begin
      internal_busy_flag <= reset_in_progress;
      if (reset_in_progress) begin
        operating_state <= lhcd_pkg::OS_RESET;
      end else if (cfg.display_control[lhcd_pkg::DC_ON]) begin
        operating_state <= lhcd_pkg::OS_NORMAL;
      end else begin
        operating_state <= lhcd_pkg::OS_SLEEP;
      end
    end
  end

  // R22 rate follows pins while in reset
  always_ff @(posedge clk) begin
    if (int_reset | reset_in_progress) begin
      multiplex_rate <= rate_s;
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  // R24 only the addressed field changes
  // R15 unknown patterns leave state alone
  always_ff @(posedge clk) begin
    if (int_reset) begin
      cfg.start_line            <= lhcd_pkg::SL_RST;
      cfg.potentiometer_level   <= lhcd_pkg::PM_RST;
      cfg.coarse_gain           <= lhcd_pkg::GN_RST;
      cfg.pump_control          <= lhcd_pkg::PC_RST;
      cfg.vendor_product_config <= lhcd_pkg::APC_RST;
      cfg.display_control       <= lhcd_pkg::DC_RST;
      cfg.address_control       <= lhcd_pkg::AC_RST;
      cfg.mapping_control       <= lhcd_pkg::LC_RST;
      cfg.bias_ratio            <= bias_s;
    end else if (reset_in_progress) begin
      // straps settle after the synchronisers
      cfg.bias_ratio <= bias_s;
    end else if (second_byte) begin
      if (pend == PEND_PM) begin
        cfg.potentiometer_level <= din_s[5:0];
      end else if (pend == PEND_APC) begin
        cfg.vendor_product_config <= din_s;
      end
    end else if (take_cmd) begin
      case (cmd)
        lhcd_pkg::CMD_GN:  cfg.coarse_gain <= din_s[2:0];
        // R16 R17 pump loading and source
        lhcd_pkg::CMD_PC:  cfg.pump_control <= din_s[2:0];
        // R18 scroll start line
        lhcd_pkg::CMD_SL:  cfg.start_line <= din_s[5:0];
        // R7 R9 wrap and direction, reserved zero
        lhcd_pkg::CMD_AC: begin
          cfg.address_control[lhcd_pkg::AC_WRAP] <= din_s[lhcd_pkg::AC_WRAP];
          cfg.address_control[lhcd_pkg::AC_RSV]  <= 1'b0;
          cfg.address_control[lhcd_pkg::AC_PID]  <= din_s[lhcd_pkg::AC_PID];
        end
        // R21 row mirror alone
        lhcd_pkg::CMD_MY:  cfg.mapping_control[lhcd_pkg::LC_MY] <= din_s[0];
        // R20 invert, all on, display on
        lhcd_pkg::CMD_APO: cfg.display_control[lhcd_pkg::DC_APO] <= din_s[0];
        lhcd_pkg::CMD_INV: cfg.display_control[lhcd_pkg::DC_INV] <= din_s[0];
        lhcd_pkg::CMD_ON:  cfg.display_control[lhcd_pkg::DC_ON] <= din_s[0];
        // R21 full mapping control
        lhcd_pkg::CMD_LC: begin
          cfg.mapping_control                    <= din_s[3:0];
          cfg.mapping_control[lhcd_pkg::LC_RSV]  <= 1'b0;
        end
        lhcd_pkg::CMD_BR:  cfg.bias_ratio <= din_s[1:0];
        // R8 cursor mode flag
        lhcd_pkg::CMD_CSET: cfg.address_control[lhcd_pkg::AC_CUM] <= 1'b1;
        lhcd_pkg::CMD_CRST: cfg.address_control[lhcd_pkg::AC_CUM] <= 1'b0;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // address pointers
  // ****************************************************************
  logic [7:0] column_pointer;
  logic [4:0] page_pointer;
  logic [7:0] cursor_return;
  logic       wrap_enable;
  logic       page_step_direction;
  logic       cursor_update_mode;

  assign wrap_enable         = cfg.address_control[lhcd_pkg::AC_WRAP];
  assign page_step_direction = cfg.address_control[lhcd_pkg::AC_PID];
  assign cursor_update_mode  = cfg.address_control[lhcd_pkg::AC_CUM];

  always_ff @(posedge clk) begin
    if (int_reset) begin
      column_pointer <= lhcd_pkg::CA_RST;
      page_pointer   <= lhcd_pkg::PA_RST;
      cursor_return  <= lhcd_pkg::CA_RST;
    end else if (take_cmd & ~second_byte) begin
      case (cmd)
        // R14 column loaded by nibbles
        lhcd_pkg::CMD_CAL:  column_pointer[3:0] <= din_s[3:0];
        lhcd_pkg::CMD_CAH:  column_pointer[7:4] <= din_s[3:0];
        lhcd_pkg::CMD_PA:   page_pointer <= {1'b0, din_s[3:0]};
        lhcd_pkg::CMD_CSET: cursor_return <= column_pointer;
        lhcd_pkg::CMD_CRST: column_pointer <= cursor_return;
        default: ;
      endcase
    end else if (take_wdata | (take_rdata & ~cursor_update_mode)) begin
      // R3 R8 automatic step, reads frozen in cursor mode
      if (column_pointer != lhcd_pkg::COL_LAST) begin
        column_pointer <= column_pointer + 8'h01;
      end else if (wrap_enable & ~cursor_update_mode) begin
        // R5 R6 R7 wrap to next page, ends join
        column_pointer <= 8'h00;
        page_pointer   <= page_step_direction ? page_pointer - 5'h01 : page_pointer + 5'h01;
      end
      // R4 otherwise stay at last column
    end
  end

  // ****************************************************************
  // display memory and read path
  // ****************************************************************
  logic [7:0]              ram [lhcd_pkg::RAM_WORDS];
  logic [7:0]              ram_col;
  logic                    col_ok;
  logic [lhcd_pkg::RAM_AW-1:0] ram_addr;
  logic                    column_mirror;
  logic                    msb_first_swap;
  logic [7:0]              status_byte;

  assign column_mirror  = cfg.mapping_control[lhcd_pkg::LC_MX];
  assign msb_first_swap = cfg.mapping_control[lhcd_pkg::LC_MSF];
  // R2 memory location from page and column
  assign ram_col  = column_mirror ? (lhcd_pkg::COL_LAST - column_pointer) : column_pointer;
  assign col_ok   = (column_pointer <= lhcd_pkg::COL_LAST);
  assign ram_addr = lhcd_pkg::RAM_AW'(page_pointer * lhcd_pkg::COLS + ram_col);
  // R10 R13 status byte layout
  assign status_byte = {internal_busy_flag, column_mirror,
                        cfg.display_control[lhcd_pkg::DC_ON], reset_in_progress, 4'h0};

  always_ff @(posedge clk) begin
    if (take_wdata & col_ok) begin
      ram[ram_addr] <= msb_first_swap ? swap_bits(din_s) : din_s;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      host_data_out <= 8'h00;
      host_data_oe  <= 1'b0;
    end else begin
      host_data_oe <= cs_s & rd_s;
      if (take_status) begin
        host_data_out <= status_byte;
      end else if (take_rdata) begin
        if (!col_ok) begin
          host_data_out <= 8'h00;
        end else if (msb_first_swap) begin
          host_data_out <= swap_bits(ram[ram_addr]);
        end else begin
          host_data_out <= ram[ram_addr];
        end
      end
    end
  end

endmodule

/* shared/lhcd_pkg.sv */
/*
  constants, command encodings and carrier types of the host command decoder.
  assumes one 25 MHz clock domain and the 132 x 32 display memory of this block.
*/
package lhcd_pkg;

  // ****************************************************************
  // geometry and timing
  // ****************************************************************
  localparam int          COLS           = 132;
  localparam int          PAGES          = 32;
  localparam int          RAM_WORDS      = COLS * PAGES;
  localparam int          RAM_AW         = 13;
  localparam logic [7:0]  COL_LAST       = 8'h83;
  localparam int          CLK_MHZ        = 25;
  localparam int          RESET_TIME_US  = 5000;
  localparam int          RESET_CYCLES   = RESET_TIME_US * CLK_MHZ;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [5:0]  SL_RST  = 6'h00;
  localparam logic [5:0]  PM_RST  = 6'h10;
  localparam logic [2:0]  GN_RST  = 3'h3;
  localparam logic [2:0]  PC_RST  = 3'h7;
  localparam logic [7:0]  APC_RST = 8'h6c;
  localparam logic [2:0]  DC_RST  = 3'h0;
  localparam logic [3:0]  AC_RST  = 4'h0;
  localparam logic [3:0]  LC_RST  = 4'h0;
  localparam logic [7:0]  CA_RST  = 8'h00;
  localparam logic [4:0]  PA_RST  = 5'h00;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int AC_WRAP = 0;
  localparam int AC_RSV  = 1;
  localparam int AC_PID  = 2;
  localparam int AC_CUM  = 3;
  localparam int LC_MSF  = 0;
  localparam int LC_RSV  = 1;
  localparam int LC_MX   = 2;
  localparam int LC_MY   = 3;
  localparam int DC_INV  = 0;
  localparam int DC_APO  = 1;
  localparam int DC_ON   = 2;
  localparam int PC_LOAD = 0;

  // ****************************************************************
  // operating state codes
  // ****************************************************************
  localparam logic [1:0] OS_RESET  = 2'h0;
  localparam logic [1:0] OS_SLEEP  = 2'h2;
  localparam logic [1:0] OS_NORMAL = 2'h3;

  // ****************************************************************
  // command masks and values
  // ****************************************************************
  localparam logic [7:0] M_NIB  = 8'hf0;
  localparam logic [7:0] M_3    = 8'hf8;
  localparam logic [7:0] M_1    = 8'hfe;
  localparam logic [7:0] M_2    = 8'hfc;
  localparam logic [7:0] M_SL   = 8'hc0;
  localparam logic [7:0] M_AC   = 8'hfa;
  localparam logic [7:0] M_LC   = 8'hf2;
  localparam logic [7:0] V_CAL  = 8'h00;
  localparam logic [7:0] V_CAH  = 8'h10;
  localparam logic [7:0] V_GN   = 8'h20;
  localparam logic [7:0] V_PC   = 8'h28;
  localparam logic [7:0] V_APC  = 8'h30;
  localparam logic [7:0] V_SL   = 8'h40;
  localparam logic [7:0] V_PA   = 8'hb0;
  localparam logic [7:0] V_PM   = 8'h81;
  localparam logic [7:0] V_AC   = 8'h88;
  localparam logic [7:0] V_MY   = 8'ha0;
  localparam logic [7:0] V_APO  = 8'ha4;
  localparam logic [7:0] V_INV  = 8'ha6;
  localparam logic [7:0] V_ON   = 8'hae;
  localparam logic [7:0] V_LC   = 8'hc0;
  localparam logic [7:0] V_SRST = 8'he2;
  localparam logic [7:0] V_NOP  = 8'he3;
  localparam logic [7:0] V_BR   = 8'he8;
  localparam logic [7:0] V_CRST = 8'hee;
  localparam logic [7:0] V_CSET = 8'hef;
  localparam logic [7:0] V_TST  = 8'he4;

  typedef enum logic [4:0] {
    CMD_CAL, CMD_CAH, CMD_GN, CMD_PC, CMD_APC, CMD_SL, CMD_PA, CMD_PM, CMD_AC,
    CMD_MY, CMD_APO, CMD_INV, CMD_ON, CMD_LC, CMD_SRST, CMD_NOP, CMD_BR,
    CMD_CRST, CMD_CSET, CMD_TST, CMD_UNDEF
  } lhcd_cmd_t;

  typedef struct packed {
    logic [5:0] start_line;
    logic [5:0] potentiometer_level;
    logic [2:0] coarse_gain;
    logic [2:0] pump_control;
    logic [7:0] vendor_product_config;
    logic [2:0] display_control;
    logic [3:0] address_control;
    logic [3:0] mapping_control;
    logic [1:0] bias_ratio;
  } lhcd_cfg_t;

endpackage

/* tb/lhcd_decoder_chk.sv */
/*
  port checker of the host command decoder.
  assumes one clk domain and the bind at the foot.
*/
`timescale 1ns/1ps
module lhcd_decoder_chk #(
  parameter int RESET_CYCLES = 20
) (
  input wire logic                clk,
  input wire logic                reset_n,
  input wire logic                chip_select0_n,
  input wire logic                chip_select1,
  input wire logic                command_data_select,
  input wire logic                host_write,
  input wire logic                host_read,
  input wire lhcd_pkg::lhcd_cfg_t cfg,
  input wire logic [1:0]          multiplex_rate,
  input wire logic [1:0]          operating_state,
  input wire logic                internal_busy_flag,
  input wire logic                reset_in_progress,
  input wire logic [7:0]          host_data_out,
  input wire logic                host_data_oe
);
  // ****************
  // helper
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  int unsigned rc;
  always_ff @(posedge clk) begin
    if (!reset_n || !reset_in_progress)
      rc <= 0;
    else
      rc <= rc + 1;
  end
  // ****************
  // assertions
  // ****************
  AST_RIP_BOUND: assert property (rc <= RESET_CYCLES + 8)
    else $error("reset timer ran too long");
  AST_BUSY_TRAIL: assert property ($fell(reset_in_progress) |-> internal_busy_flag ##1 !internal_busy_flag)
    else $error("busy did not trail reset flag");
  AST_OE_CAUSE: assert property ($rose(host_data_oe) |-> host_read && !chip_select0_n && chip_select1)
    else $error("bus driven without a selected read");
  AST_OE_DROP: assert property ($fell(host_read) |-> ##[1:6] !host_data_oe)
    else $error("bus still driven after read");
  AST_STATUS_LOW: assert property ($rose(host_data_oe) && !command_data_select |-> host_data_out[3:0] == 4'h0)
    else $error("status low bits not zero");
  AST_STATUS_MIRROR: assert property ($rose(host_data_oe) && !command_data_select
    |-> host_data_out[6:5] == {cfg.mapping_control[2], cfg.display_control[2]})
    else $error("status mirror or enable bit wrong");
  AST_OP_STATE: assert property (!reset_in_progress && !$past(reset_in_progress) && $stable(cfg.display_control)
    |-> operating_state == {1'b1, cfg.display_control[2]})
    else $error("operating state wrong");
  AST_MUX_FIXED: assert property (!reset_in_progress |-> $stable(multiplex_rate))
    else $error("multiplex rate changed");
  AST_RSV_ZERO: assert property (!cfg.address_control[1] && !cfg.mapping_control[1])
    else $error("reserved bit set");
  AST_CFG_QUIET: assert property ($changed(cfg) |-> $past(host_write, 2) || reset_in_progress)
    else $error("settings changed without a write");
  COV_STATUS: cover property ($rose(host_data_oe) && !command_data_select);
  COV_DATA: cover property ($rose(host_data_oe) && command_data_select);
  COV_READY: cover property ($fell(reset_in_progress));
endmodule
bind lhcd_decoder lhcd_decoder_chk #(.RESET_CYCLES(RESET_CYCLES)) i_chk (.clk, .reset_n, .chip_select0_n,
  .chip_select1, .command_data_select, .host_write, .host_read, .cfg, .multiplex_rate, .operating_state,
  .internal_busy_flag, .reset_in_progress, .host_data_out, .host_data_oe);

/* tb/lhcd_host_model.sv */
/*
  host model: byte transfers on the decoder's level strobes.
  assumes one caller at a time on clk.
*/
`timescale 1ns/1ps
module lhcd_host_model (
  input  wire logic  clk,
  output logic       chip_select0_n,
  output logic       chip_select1,
  output logic       command_data_select,
  output logic       host_write,
  output logic       host_read,
  output logic [7:0] host_data_in
);
  int slow = 0;
  initial begin
    chip_select0_n = 1'b1;
    chip_select1 = 1'b1;
    command_data_select = 1'b0;
    host_write = 1'b0;
    host_read = 1'b0;
    host_data_in = 8'h00;
  end
  // ****************
  // transfers
  // ****************
  // select low for command, high for data
  task automatic xfer(input logic cd, input logic wr, input logic [7:0] b);
    @(posedge clk);
    chip_select0_n <= 1'b0;
    command_data_select <= cd;
    host_data_in <= b;
    repeat (3) @(posedge clk);
    host_write <= wr;
    host_read <= !wr;
    repeat (6 + slow) @(posedge clk);
    host_write <= 1'b0;
    host_read <= 1'b0;
    repeat (6) @(posedge clk);
    chip_select0_n <= 1'b1;
    host_data_in <= ~b;
  endtask
endmodule

/* tb/tb_top.sv */
/*
  self-checking bench of the host command decoder.
  assumes the host model, the checker bind and a short reset timer.
*/
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
  $display("mismatch %s expected %h seen %h", n, e, a); end end
module tb_top;
  // ****************
  // signals
  // ****************
  logic                clk, reset_n, rst_pin_n, oe_q;
  logic                chip_select0_n, chip_select1, command_data_select, host_write, host_read;
  logic [7:0]          host_data_in, host_data_out, ex, d0, d1, d2;
  logic [1:0]          rate_pins, bias_pins, multiplex_rate, operating_state;
  logic                internal_busy_flag, reset_in_progress, host_data_oe;
  lhcd_pkg::lhcd_cfg_t cfg, ec;
  logic [7:0]          q[$];
  logic [7:0]          cl[6] = '{8'h25, 8'h7f, 8'ha7, 8'ha5, 8'haf, 8'hcd};
  int                  fail_count, tests_run, seed;
  lhcd_host_model i_host (.clk, .chip_select0_n, .chip_select1, .command_data_select, .host_write, .host_read,
    .host_data_in);
  lhcd_decoder #(.RESET_CYCLES(40)) i_dut (.clk, .reset_n, .rst_pin_n, .chip_select0_n, .chip_select1,
    .command_data_select, .host_write, .host_read, .host_data_in, .rate_pins, .bias_pins, .cfg, .multiplex_rate,
    .operating_state, .internal_busy_flag, .reset_in_progress, .host_data_out, .host_data_oe);
  // ****************
  // tasks
  // ****************
  always @(negedge clk) begin
    oe_q <= host_data_oe;
    if (host_data_oe === 1'b1 && oe_q === 1'b0) begin
      ex = (q.size() > 0) ? q.pop_front() : 8'hxx;
      `CHK("host_data_out", ex, host_data_out)
    end
  end
  task automatic cmd(input logic [7:0] b);
    i_host.xfer(1'b0, 1'b1, b);
  endtask
  task automatic dat(input logic [7:0] b);
    i_host.xfer(1'b1, 1'b1, b);
  endtask
  task automatic rdx(input logic c, input logic [7:0] e);
    q.push_back(e);
    i_host.xfer(c, 1'b0, 8'h00);
  endtask
  task automatic col(input logic [7:0] c);
    cmd({4'h0, c[3:0]});
    cmd({4'h1, c[7:4]});
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wait_ready(input string s);
    int n;
    n = 0;
    while (reset_in_progress !== 1'b0 && n < 300) begin // hold off until ready
      @(posedge clk);
      n++;
    end
    if (n >= 300) begin
      fail_count++;
      print_verdict();
    end else begin
      @(negedge clk);
      $display("test %s done", s);
    end
  endtask
  // ****************
  // run
  // ****************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    seed = 32'h1c7ad6bd;
    fail_count = 0;
    tests_run = 0;
    reset_n = 1'b0;
    rst_pin_n = 1'b1;
    rate_pins = 2'($random(seed));
    bias_pins = 2'($random(seed));
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    d2 = 8'($random(seed));
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    rdx(1'b0, 8'h90);
    wait_ready("reset");
    ec = {6'h00, 6'h10, 3'h3, 3'h7, 8'h6c, 3'h0, 4'h0, 4'h0, bias_pins};
    `CHK("cfg", ec, cfg)
    `CHK("multiplex_rate", rate_pins, multiplex_rate)
    `CHK("operating_state", lhcd_pkg::OS_SLEEP, operating_state)
    for (int i = 0; i < 8; i++) begin
      cmd(8'h28 | 8'(i));
      `CHK("pump_control", 3'(i), cfg.pump_control)
    end
    foreach (cl[i]) cmd(cl[i]);
    cmd(8'h81);
    dat(d0);
    cmd(8'hff);
    ec = {6'h3f, 6'h3f, 3'h5, 3'h7, 8'h6c, 3'h7, 4'h0, 4'hd, bias_pins};
    `CHK("cfg", ec, cfg)
    `CHK("operating_state", lhcd_pkg::OS_NORMAL, operating_state)
    rdx(1'b0, 8'h60);
    cmd(8'hc0);
    cmd(8'h8d);
    cmd(8'hb0);
    col(8'h82);
    dat(d0);
    dat(d1);
    dat(d2);
    cmd(8'hb0);
    col(8'h82);
    rdx(1'b1, d0);
    rdx(1'b1, d1);
    rdx(1'b1, d2);
    cmd(8'h89);
    cmd(8'hbf);
    col(8'h83);
    dat(d1);
    dat(d0);
    cmd(8'hbf);
    col(8'h83);
    rdx(1'b1, d1);
    rdx(1'b1, d0);
    cmd(8'h88);
    cmd(8'hb2);
    col(8'h83);
    dat(d0);
    dat(d2);
    col(8'h83);
    rdx(1'b1, d2);
    rdx(1'b1, d2);
    i_host.slow = 4;
    cmd(8'hb3);
    col(8'h05);
    dat(d0);
    dat(d1);
    col(8'h05);
    cmd(8'hef);
    rdx(1'b1, d0);
    rdx(1'b1, d0);
    dat(d2);
    rdx(1'b1, d1);
    cmd(8'hee);
    rdx(1'b1, d2);
    i_host.slow = 0;
    cmd(8'he2);
    rdx(1'b0, 8'h90);
    wait_ready("pointers and system reset");
    ec = {6'h00, 6'h10, 3'h3, 3'h7, 8'h6c, 3'h0, 4'h0, 4'h0, bias_pins};
    `CHK("cfg", ec, cfg)
    `CHK("read queue", 0, q.size())
    print_verdict();
  end
endmodule
